// File: positioning_start_selector_tb.sv
// Self-checking bench for host and device ends joined by the link
module positioning_start_selector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic op_launch, op_done, map_we, flag_we, flag_wdata;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] op_number, start_point, map_wdata, flag_addr, ev, n, v;
  logic [2:0] map_idx;
  logic [6:0] current_number;
  logic [5:0] exp_q[$];
  integer seed, num_errors, n_checks, cycles, i;

  pss_link_if link();
  pss_host u_pss_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  pss_device u_pss_device (.pclk(pclk), .presetn(presetn), .link(link),
    .op_launch(op_launch), .op_number(op_number), .op_done(op_done),
    .ev_non_positioning(ev[0]), .ev_alarm_reset(ev[1]), .ev_stop(ev[2]),
    .ev_non_excitation(ev[3]), .ev_position_preset(ev[4]),
    .ev_configuration(ev[5]), .map_we(map_we), .map_idx(map_idx),
    .map_wdata(map_wdata), .flag_we(flag_we), .flag_addr(flag_addr),
    .flag_wdata(flag_wdata), .start_point(start_point),
    .current_number(current_number));
  pss_link_properties u_pss_link_properties (.pclk(pclk),
    .presetn(presetn), .data_select_bit0(link.data_select_bit0),
    .data_select_bit1(link.data_select_bit1),
    .data_select_bit2(link.data_select_bit2),
    .data_select_bit3(link.data_select_bit3),
    .data_select_bit4(link.data_select_bit4),
    .data_select_bit5(link.data_select_bit5),
    .direct_start_in0(link.direct_start_in0),
    .direct_start_in1(link.direct_start_in1),
    .direct_start_in2(link.direct_start_in2),
    .direct_start_in3(link.direct_start_in3),
    .direct_start_in4(link.direct_start_in4),
    .direct_start_in5(link.direct_start_in5),
    .start_request(link.start_request),
    .sequence_step_request(link.sequence_step_request),
    .ready(link.ready), .motion_active(link.motion_active));

  always #25 pclk = ~pclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : check

  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task check_seq(input logic [5:0] sp, input logic [6:0] cur);
    check(start_point, sp, "start point");
    check(current_number, cur, "current number");
  endtask : check_seq

  task run_op(input logic [1:0] m, input logic [5:0] num,
              input logic [5:0] exp);
    integer k;
    exp_q.push_back(exp);
    apb(1'b1, pss_pkg::CMD_OFFSET, {15'h0, 1'b1, 6'h0, m, 2'h0, num});
    for (k = 0; k < 20 && link.ready !== 1'b0; k++) @(posedge pclk);
    // Status read while the motor moves
    apb(1'b0, pss_pkg::STATUS_OFFSET, 32'h0);
    check(rd[2:0], 3'b010, "status in motion");
    op_done <= 1'b1;
    @(posedge pclk);
    op_done <= 1'b0;
    rd = 32'h4;
    for (k = 0; k < 20 && rd[2:0] !== 3'b001; k++) begin
      apb(1'b0, pss_pkg::STATUS_OFFSET, 32'h0);
    end
    check(rd[2:0], 3'b001, "status after op");
  endtask : run_op

  task cfg(input logic fl, input logic [5:0] a, input logic [5:0] d);
    @(posedge pclk);
    flag_we <= fl;
    flag_addr <= a;
    flag_wdata <= 1'b1;
    map_we <= !fl;
    map_idx <= a[2:0];
    map_wdata <= d;
    @(posedge pclk);
    flag_we <= 1'b0;
    map_we <= 1'b0;
  endtask : cfg

  // ----------------------------------------
  // Launch monitor and timeout
  // ----------------------------------------
  always @(posedge pclk) begin
    if (presetn === 1'b1 && op_launch === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: unexpected launch", $time);
      end else begin
        check(op_number, exp_q.pop_front(), "launched number");
      end
    end
    cycles = cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'he7fd696c;
    {num_errors, n_checks, cycles} = '0;
    {pclk, presetn, psel, penable, pwrite, op_done} = '0;
    {map_we, flag_we, flag_wdata, map_idx, map_wdata, flag_addr} = '0;
    {paddr, pwdata, ev} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pss_pkg::STATUS_OFFSET, 32'h0);
    check(rd, 32'h1, "status at reset");
    apb(1'b1, 8'h08, 32'hffffffff);
    check(err, 1'b1, "unmapped write error");
    apb(1'b0, 8'h08, 32'h0);
    check(err, 1'b1, "unmapped read error");
    check(rd, 32'h0, "unmapped read");
    apb(1'b0, pss_pkg::CMD_OFFSET, 32'h0);
    check(rd, pss_pkg::CMD_RST, "command at reset");
    apb(1'b1, pss_pkg::CMD_OFFSET, 32'h00010106);
    apb(1'b0, pss_pkg::CMD_OFFSET, 32'h0);
    check(rd, 32'h00010106, "command readback");
    apb(1'b0, pss_pkg::STATUS_OFFSET, 32'h0);
    check(rd, 32'h1, "unassigned direct refused");
    check_seq(6'h00, 7'h7f);
    $display("test reset done");
    cfg(1'b1, 6'h01, 6'h00);
    run_op(pss_pkg::PSS_STEP, 6'h00, 6'h00);
    run_op(pss_pkg::PSS_STEP, 6'h00, 6'h01);
    run_op(pss_pkg::PSS_STEP, 6'h00, 6'h00);
    check_seq(6'h00, 7'h00);
    $display("test step done");
    v = 6'($random(seed));
    n = {1'b0, v[4:0]} + 6'h01;
    cfg(1'b1, n + 6'h01, 6'h00);
    run_op(pss_pkg::PSS_SELECT_START, n, n);
    check_seq(n, {1'b0, n});
    run_op(pss_pkg::PSS_STEP, 6'h00, n + 6'h01);
    run_op(pss_pkg::PSS_STEP, 6'h00, n);
    run_op(pss_pkg::PSS_SELECT_START, 6'h3f, 6'h3f);
    run_op(pss_pkg::PSS_STEP, 6'h00, 6'h3f);
    $display("test select done");
    for (i = 0; i < 6; i++) begin
      run_op(pss_pkg::PSS_DIRECT, 6'(i), 6'(i));
    end
    check_seq(6'h05, 7'h05);
    v = 6'($random(seed));
    cfg(1'b0, 6'h03, v);
    run_op(pss_pkg::PSS_DIRECT, 6'h03, v);
    check_seq(v, {1'b0, v});
    $display("test direct done");
    for (i = 0; i < 6; i++) begin
      run_op(pss_pkg::PSS_DIRECT, 6'h01, 6'h01);
      @(posedge pclk);
      ev <= 6'h01 << i;
      @(posedge pclk);
      ev <= 6'h00;
      @(posedge pclk);
      check_seq(6'h00, 7'h7f);
    end
    run_op(pss_pkg::PSS_STEP, 6'h00, 6'h00);
    check(exp_q.size(), 32'h0, "launches outstanding");
    $display("test events done");
    finish_test();
  end
endmodule : positioning_start_selector_tb

// File: pss_device.sv
// Device end: start selection, direct map and sequence stepping
//
// Register access over APB and the register addresses were chosen for this implementation.
module pss_device (
  input wire logic pclk,
  input wire logic presetn,
  pss_link_if.dev link,
  output logic op_launch,
  output logic [5:0] op_number,
  input wire logic op_done,
  input wire logic ev_non_positioning,
  input wire logic ev_alarm_reset,
  input wire logic ev_stop,
  input wire logic ev_non_excitation,
  input wire logic ev_position_preset,
  input wire logic ev_configuration,
  input wire logic map_we,
  input wire logic [2:0] map_idx,
  input wire logic [5:0] map_wdata,
  input wire logic flag_we,
  input wire logic [5:0] flag_addr,
  input wire logic flag_wdata,
  output logic [5:0] start_point,
  output logic [6:0] current_number
);

  // ----------------------------------------
  // Helper
  // ----------------------------------------
  // Lowest set bit wins when several direct inputs rise together
  function automatic logic [pss_pkg::DIRECT_IDX_W-1:0] pss_first_set(
      input logic [pss_pkg::DIRECT_N-1:0] v);
    logic [pss_pkg::DIRECT_IDX_W-1:0] idx;
    idx = '0;
    for (int i = pss_pkg::DIRECT_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = pss_pkg::DIRECT_IDX_W'(i);
      end
    end
    return idx;
  endfunction : pss_first_set

  // ----------------------------------------
  // State
  // ----------------------------------------
  pss_pkg::pss_dev_state_t state_ff;
  pss_pkg::pss_dev_state_t nxt_state;
  logic start_prev_ff;
  logic step_prev_ff;
  logic [pss_pkg::DIRECT_N-1:0] direct_prev_ff;
  logic [pss_pkg::NUM_W*pss_pkg::DIRECT_N-1:0] map_ff;
  logic [pss_pkg::ENTRY_N-1:0] flags_ff;
  logic [pss_pkg::NUM_W-1:0] sp_ff;
  logic [pss_pkg::NUM_W-1:0] nxt_sp;
  logic [pss_pkg::NUM_W:0] cur_ff;
  logic [pss_pkg::NUM_W:0] nxt_cur;
  logic launch_ff;
  logic [pss_pkg::NUM_W-1:0] number_ff;
  logic [pss_pkg::NUM_W-1:0] nxt_number;

  // ----------------------------------------
  // Input decode
  // ----------------------------------------
  wire logic [pss_pkg::NUM_W-1:0] sel_num = {link.data_select_bit5,
      link.data_select_bit4, link.data_select_bit3, link.data_select_bit2,
      link.data_select_bit1, link.data_select_bit0};
  wire logic [pss_pkg::DIRECT_N-1:0] direct_in = {link.direct_start_in5,
      link.direct_start_in4, link.direct_start_in3, link.direct_start_in2,
      link.direct_start_in1, link.direct_start_in0};
  wire logic idle = (state_ff == pss_pkg::PSS_DEV_IDLE);
  wire logic start_rise = link.start_request & ~start_prev_ff;
  wire logic step_rise = link.sequence_step_request & ~step_prev_ff;
  wire logic [pss_pkg::DIRECT_N-1:0] direct_rise = direct_in &
      ~direct_prev_ff;
  wire logic direct_any = |direct_rise;
  wire logic [pss_pkg::DIRECT_IDX_W-1:0] direct_idx =
      pss_first_set(direct_rise);
  wire logic [pss_pkg::NUM_W-1:0] direct_num =
      map_ff[direct_idx*pss_pkg::NUM_W +: pss_pkg::NUM_W];
  wire logic seq_event = ev_non_positioning | ev_alarm_reset | ev_stop |
      ev_non_excitation | ev_position_preset | ev_configuration;

  // ----------------------------------------
  // Sequence stepping
  // ----------------------------------------
  wire logic cur_none = (cur_ff == pss_pkg::CUR_NONE);
  wire logic cur_last = (cur_ff[pss_pkg::NUM_W-1:0] == pss_pkg::NUM_LAST);
  wire logic [pss_pkg::NUM_W-1:0] step_follow =
      cur_ff[pss_pkg::NUM_W-1:0] + 6'h01;
  wire logic follow_ok = ~cur_none & ~cur_last & flags_ff[step_follow];
  wire logic [pss_pkg::NUM_W-1:0] step_num =
      follow_ok ? step_follow : sp_ff;

  // Requests count only while ready is on
  wire logic take_start = idle & ~seq_event & start_rise;
  wire logic take_direct = idle & ~seq_event & ~start_rise &
      direct_any;
  wire logic take_step = idle & ~seq_event & ~start_rise & ~direct_any &
      step_rise;
  wire logic take_any = take_start | take_direct | take_step;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pss_pkg::PSS_DEV_IDLE: begin
        if (take_any) begin
          nxt_state = pss_pkg::PSS_DEV_BUSY;
        end
      end
      pss_pkg::PSS_DEV_BUSY: begin
        if (op_done) begin
          nxt_state = pss_pkg::PSS_DEV_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    nxt_number = number_ff;
    nxt_sp = sp_ff;
    nxt_cur = cur_ff;
    if (seq_event) begin
      nxt_sp = pss_pkg::START_POINT_RST;
      nxt_cur = pss_pkg::CUR_NONE;
    end else if (take_start) begin
      nxt_number = sel_num;
      nxt_sp = sel_num;
      nxt_cur = {1'b0, sel_num};
    end else if (take_direct) begin
      nxt_number = direct_num;
      nxt_sp = direct_num;
      nxt_cur = {1'b0, direct_num};
    end else if (take_step) begin
      nxt_number = step_num;
      nxt_cur = {1'b0, step_num};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= pss_pkg::PSS_DEV_IDLE;
      launch_ff <= 1'b0;
      number_ff <= '0;
      sp_ff <= pss_pkg::START_POINT_RST;
      cur_ff <= pss_pkg::CUR_NONE;
    end else begin
      state_ff <= nxt_state;
      launch_ff <= take_any;
      number_ff <= nxt_number;
      sp_ff <= nxt_sp;
      cur_ff <= nxt_cur;
    end
  end

  // Previous input levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_ff <= 1'b0;
      step_prev_ff <= 1'b0;
      direct_prev_ff <= '0;
    end else begin
      start_prev_ff <= link.start_request;
      step_prev_ff <= link.sequence_step_request;
      direct_prev_ff <= direct_in;
    end
  end

  // Direct map and sequential flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_ff <= pss_pkg::DIRECT_MAP_RST;
      flags_ff <= pss_pkg::SEQ_FLAGS_RST;
    end else begin
      if (map_we && (map_idx < 3'(pss_pkg::DIRECT_N))) begin
        map_ff[map_idx*pss_pkg::NUM_W +: pss_pkg::NUM_W] <= map_wdata;
      end
      if (flag_we) begin
        flags_ff[flag_addr] <= flag_wdata;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.ready = idle;
  assign link.motion_active = ~idle;
  assign op_launch = launch_ff;
  assign op_number = number_ff;
  assign start_point = sp_ff;
  assign current_number = cur_ff;

endmodule : pss_device

// File: pss_host.sv
// Host end: APB command registers driving the discrete start lines
module pss_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pss_link_if.host link
);

  // ----------------------------------------
  // State and registers
  // ----------------------------------------
  pss_pkg::pss_host_state_t state_ff;
  pss_pkg::pss_host_state_t nxt_state;
  logic [31:0] cmd_ff;
  logic [5:0] sel_ff;
  logic [5:0] direct_ff;
  logic start_ff;
  logic step_ff;
  logic req_on;
  logic req_off;
  logic [31:0] rdata_ff;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic access = psel & penable;
  wire logic hit_cmd = (paddr == pss_pkg::CMD_OFFSET);
  wire logic hit_status = (paddr == pss_pkg::STATUS_OFFSET);
  wire logic cmd_wr = access & pwrite & hit_cmd;
  wire logic host_idle = (state_ff == pss_pkg::PSS_HOST_IDLE);
  wire logic go = cmd_wr & pwdata[pss_pkg::CMD_GO_BIT] & host_idle;
  wire logic [5:0] cmd_num = cmd_ff[pss_pkg::CMD_NUM_LSB +: 6];
  wire logic [1:0] cmd_method = cmd_ff[pss_pkg::CMD_METHOD_LSB +: 2];
  wire logic [31:0] status_word = {29'h0,
      ~host_idle, link.motion_active, link.ready};

  assign pready = 1'b1;
  assign pslverr = access & ~hit_cmd & ~hit_status;
  wire logic [31:0] read_mux = hit_cmd ? cmd_ff :
      (hit_status ? status_word : 32'h0);
  wire logic setup = psel & ~penable;
  // Unassigned direct index or unused method raises no line
  wire logic cmd_void = (cmd_method == pss_pkg::PSS_DIRECT &&
      cmd_num >= 6'(pss_pkg::DIRECT_N)) || (cmd_method == 2'h3);
  assign prdata = rdata_ff;

  // ----------------------------------------
  // Request sequencing
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    req_on = 1'b0;
    req_off = 1'b0;
    unique case (state_ff)
      pss_pkg::PSS_HOST_IDLE: begin
        if (go) begin
          nxt_state = pss_pkg::PSS_HOST_WAIT;
        end
      end
      pss_pkg::PSS_HOST_WAIT: begin
        if (cmd_void) begin
          nxt_state = pss_pkg::PSS_HOST_IDLE;
        end else if (link.ready) begin
          req_on = 1'b1;
          nxt_state = pss_pkg::PSS_HOST_HOLD;
        end
      end
      pss_pkg::PSS_HOST_HOLD: begin
        if (!link.ready) begin
          req_off = 1'b1;
          nxt_state = pss_pkg::PSS_HOST_IDLE;
        end
      end
      default: begin
        nxt_state = pss_pkg::PSS_HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= pss_pkg::PSS_HOST_IDLE;
      cmd_ff <= pss_pkg::CMD_RST;
      sel_ff <= '0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      // Read word taken in setup phase so prdata comes from a flop
      if (setup) begin
        rdata_ff <= read_mux;
      end
      if (cmd_wr && host_idle) begin
        cmd_ff <= pwdata;
        sel_ff <= pwdata[pss_pkg::CMD_NUM_LSB +: 6];
      end
    end
  end

  // Request lines are raised once ready is seen, held until it drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_ff <= 1'b0;
      step_ff <= 1'b0;
      direct_ff <= '0;
    end else if (req_off) begin
      start_ff <= 1'b0;
      step_ff <= 1'b0;
      direct_ff <= '0;
    end else if (req_on) begin
      start_ff <= (cmd_method == pss_pkg::PSS_SELECT_START);
      step_ff <= (cmd_method == pss_pkg::PSS_STEP);
      direct_ff <= (cmd_method == pss_pkg::PSS_DIRECT &&
          cmd_num < 6'(pss_pkg::DIRECT_N)) ? 6'h01 << cmd_num[2:0] : 6'h00;
    end
  end

  // ----------------------------------------
  // Link outputs
  // ----------------------------------------
  assign link.data_select_bit0 = sel_ff[0];
  assign link.data_select_bit1 = sel_ff[1];
  assign link.data_select_bit2 = sel_ff[2];
  assign link.data_select_bit3 = sel_ff[3];
  assign link.data_select_bit4 = sel_ff[4];
  assign link.data_select_bit5 = sel_ff[5];
  assign link.direct_start_in0 = direct_ff[0];
  assign link.direct_start_in1 = direct_ff[1];
  assign link.direct_start_in2 = direct_ff[2];
  assign link.direct_start_in3 = direct_ff[3];
  assign link.direct_start_in4 = direct_ff[4];
  assign link.direct_start_in5 = direct_ff[5];
  assign link.start_request = start_ff;
  assign link.sequence_step_request = step_ff;

endmodule : pss_host

// File: pss_link_if.sv
// Discrete start and select lines between host and device
interface pss_link_if;
  logic data_select_bit0;
  logic data_select_bit1;
  logic data_select_bit2;
  logic data_select_bit3;
  logic data_select_bit4;
  logic data_select_bit5;
  logic direct_start_in0;
  logic direct_start_in1;
  logic direct_start_in2;
  logic direct_start_in3;
  logic direct_start_in4;
  logic direct_start_in5;
  logic start_request;
  logic sequence_step_request;
  logic ready;
  logic motion_active;

  modport dev (
    input data_select_bit0, data_select_bit1, data_select_bit2,
    input data_select_bit3, data_select_bit4, data_select_bit5,
    input direct_start_in0, direct_start_in1, direct_start_in2,
    input direct_start_in3, direct_start_in4, direct_start_in5,
    input start_request, sequence_step_request,
    output ready, motion_active
  );

  modport host (
    output data_select_bit0, data_select_bit1, data_select_bit2,
    output data_select_bit3, data_select_bit4, data_select_bit5,
    output direct_start_in0, direct_start_in1, direct_start_in2,
    output direct_start_in3, direct_start_in4, direct_start_in5,
    output start_request, sequence_step_request,
    input ready, motion_active
  );
endinterface : pss_link_if

// File: pss_link_properties.sv
// Concurrent checks on the link between host and device ends
module pss_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic data_select_bit0,
  input wire logic data_select_bit1,
  input wire logic data_select_bit2,
  input wire logic data_select_bit3,
  input wire logic data_select_bit4,
  input wire logic data_select_bit5,
  input wire logic direct_start_in0,
  input wire logic direct_start_in1,
  input wire logic direct_start_in2,
  input wire logic direct_start_in3,
  input wire logic direct_start_in4,
  input wire logic direct_start_in5,
  input wire logic start_request,
  input wire logic sequence_step_request,
  input wire logic ready,
  input wire logic motion_active
);
  logic [5:0] sel;
  logic [5:0] direct;
  logic any_direct;
  logic any_req;
  assign sel = {data_select_bit5, data_select_bit4, data_select_bit3,
                data_select_bit2, data_select_bit1, data_select_bit0};
  assign direct = {direct_start_in5, direct_start_in4, direct_start_in3,
                   direct_start_in2, direct_start_in1, direct_start_in0};
  assign any_direct = |direct;
  assign any_req = start_request | any_direct | sequence_step_request;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_motion_inverse: assert property (
    motion_active == !ready)
    else $error("motion active not inverse of ready");
  a_launch_drops_ready: assert property (
    $rose(any_req) && ready |=> !ready && motion_active)
    else $error("ready stayed on after a request");
  a_ready_falls_cause: assert property (
    $fell(ready) |-> $past(any_req))
    else $error("ready fell without a request");
  a_req_when_ready: assert property (
    $rose(any_req) |-> ready)
    else $error("request raised while not ready");
  a_start_held: assert property (
    start_request && ready |=> start_request)
    else $error("start released before ready fell");
  a_direct_held: assert property (
    any_direct && ready |=> any_direct)
    else $error("direct input released before ready fell");
  a_step_held: assert property (
    sequence_step_request && ready |=> sequence_step_request)
    else $error("step released before ready fell");
  a_release_after: assert property (
    $fell(any_req) |-> !$past(ready))
    else $error("request released while ready on");
  a_one_method: assert property (
    $onehot0({start_request, direct, sequence_step_request}))
    else $error("more than one request line on");
  a_select_stable: assert property (
    start_request [*2] |-> $stable(sel))
    else $error("select bits moved under start");
endmodule : pss_link_properties

// File: pss_pkg.sv
// Constants and types shared by both ends of the start selector link
package pss_pkg;

  // ----------------------------------------
  // Data numbers and entries
  // ----------------------------------------
  localparam int NUM_W = 6;
  localparam int ENTRY_N = 64;
  localparam int DIRECT_N = 6;
  localparam int DIRECT_IDX_W = 3;
  localparam logic [NUM_W-1:0] NUM_LAST = 6'h3f;
  localparam logic [NUM_W-1:0] START_POINT_RST = 6'h00;
  // Current number is signed: all ones means none (-1)
  localparam logic [NUM_W:0] CUR_NONE = 7'h7f;
  localparam logic [ENTRY_N-1:0] SEQ_FLAGS_RST = 64'h0;
  localparam logic [NUM_W*DIRECT_N-1:0] DIRECT_MAP_RST =
      {6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};

  // ----------------------------------------
  // Controller registers over APB
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CMD_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam int CMD_NUM_LSB = 0;
  localparam int CMD_METHOD_LSB = 8;
  localparam int CMD_GO_BIT = 16;
  localparam int ST_READY_BIT = 0;
  localparam int ST_MOTION_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam logic [31:0] CMD_RST = 32'h0;

  typedef enum logic [1:0] {
    PSS_SELECT_START = 2'b00,
    PSS_DIRECT = 2'b01,
    PSS_STEP = 2'b10
  } pss_method_t;

  typedef enum logic {
    PSS_DEV_IDLE = 1'b0,
    PSS_DEV_BUSY = 1'b1
  } pss_dev_state_t;

  typedef enum logic [1:0] {
    PSS_HOST_IDLE = 2'b00,
    PSS_HOST_WAIT = 2'b01,
    PSS_HOST_HOLD = 2'b10
  } pss_host_state_t;

endpackage : pss_pkg
